// *** hw/adsq_clkdiv.sv ***
// Converter clock divider: one-cycle tick at the selected divided rate
`timescale 1ns/1ps
module adsq_clkdiv
  import adsq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] limit;

  // Terminal count is divide ratio minus one
  assign limit   = 7'((8'h01 << div_sel) - 8'h01); // R18
  assign tick    = run && (cnt_r == limit);         // R16
  assign cnt_nxt = (!run || tick) ? 7'h00 : cnt_r + 7'h01;

  // Counter restarts with each conversion so phase is fixed
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : adsq_clkdiv

// *** hw/adsq_ctrl.sv ***
// Converter sequencer control: registers, start detect, timing, routing
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module adsq_ctrl
  import adsq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  input  wire logic [11:0] conv_data,
  output logic             analog_power_on,
  output logic             sample_hold,
  output logic             result_latch,
  output logic [1:0]       ref_route,
  output logic [7:0]       analog_input_pins_sel,
  output logic [4:0]       internal_route,
  output logic [7:0]       pin_pullup_disable,
  output logic [7:0]       pin_digital_disable,
  output logic [7:0]       pin_dir_override,
  output logic             conversion_irq
);
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [7:0]  pinsel_r;
  logic        start_r;
  logic        armed_r;
  logic        busy_r;
  logic        irq_flag_r;
  logic        irq_en_r;
  logic        master_en_r;
  logic [11:0] result_r;
  logic [4:0]  period_r;
  logic [7:0]  rdata_r;
  adsq_state_t state_r;
  adsq_state_t state_nxt;

  logic        converter_power_enable;
  logic        result_format_select;
  logic [3:0]  external_channel_select;
  logic [2:0]  internal_input_select;
  logic [1:0]  reference_source_select;
  logic [2:0]  conversion_clock_divider;
  logic        wr_c0;
  logic        wr_c1;
  logic        wr_pin;
  logic        wr_irq;
  logic        new_start;
  logic        start_fall;
  logic        tick;
  logic        last_tick;
  logic        ext_mode;
  logic [7:0]  result_high_byte;
  logic [7:0]  result_low_byte;
  logic [7:0]  rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  assign converter_power_enable   = ctrl0_r[ADSQ_C0_PWR];
  assign result_format_select     = ctrl0_r[ADSQ_C0_FMT];
  assign external_channel_select  = ctrl0_r[ADSQ_C0_CHAN_LO +: 4];
  assign internal_input_select    = ctrl1_r[ADSQ_C1_INS_LO +: 3];
  assign reference_source_select  = ctrl1_r[ADSQ_C1_REF_LO +: 2];
  assign conversion_clock_divider = ctrl1_r[ADSQ_C1_DIV_LO +: 3];

  assign wr_c0  = wr && (addr == ADSQ_ADDR_CTRL0);
  assign wr_c1  = wr && (addr == ADSQ_ADDR_CTRL1);
  assign wr_pin = wr && (addr == ADSQ_ADDR_PINSEL);
  assign wr_irq = wr && (addr == ADSQ_ADDR_IRQ);

  ////////////////////////////////////////////////////////////////////////
  // Start pulse: a rise arms, the following fall launches the conversion.
  // A pulse while powered down is dropped so no result is faked.
  assign new_start  = wr_c0 ? wdata[ADSQ_C0_START] : start_r;
  assign start_fall = start_r && !new_start && armed_r
                      && converter_power_enable; // R12

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      start_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      start_r <= new_start;
      armed_r <= (new_start && !start_r) ? 1'b1
               : (!new_start ? 1'b0 : armed_r); // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clock tick source
  adsq_clkdiv u_div (
    .clock   (clock),
    .nrst    (nrst),
    .run     (state_r != ADSQ_IDLE),
    .div_sel (conversion_clock_divider),
    .tick    (tick)
  ); // R16

  assign last_tick = tick && (period_r == ADSQ_TOTAL_CNT - 5'h01);

  // Sequence: sampling phase then conversion phase, counted in ticks.
  // Runs alone in hardware; software is never stalled.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADSQ_IDLE: begin
        if (start_fall) state_nxt = ADSQ_SAMPLE; // R11
      end
      ADSQ_SAMPLE: begin
        if (!converter_power_enable) state_nxt = ADSQ_IDLE;
        else if (tick && period_r == ADSQ_SAMPLE_CNT - 5'h01)
          state_nxt = ADSQ_CONV; // R10
      end
      ADSQ_CONV: begin
        if (!converter_power_enable || last_tick)
          state_nxt = ADSQ_IDLE; // R10
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r  <= ADSQ_IDLE;
      period_r <= 5'h00;
    end else begin
      state_r  <= state_nxt;
      period_r <= (state_r == ADSQ_IDLE) ? 5'h00
                : (tick ? period_r + 5'h01 : period_r); // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy, result capture and request flag.
  // A launch beats the completion clear of busy, never both at once.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_r     <= 1'b0;
      result_r   <= 12'h000;
      irq_flag_r <= 1'b0;
    end else begin
      if (state_r == ADSQ_IDLE && start_fall) busy_r <= 1'b1; // R19
      else if (state_nxt == ADSQ_IDLE) busy_r <= 1'b0;       // R13
      if (state_r == ADSQ_CONV && last_tick)
        result_r <= conv_data; // R13
      // Hardware set wins over a software clear in the same cycle
      if (state_r == ADSQ_CONV && last_tick) irq_flag_r <= 1'b1; // R19
      else if (wr_irq && !wdata[ADSQ_IRQ_FLAG]) irq_flag_r <= 1'b0;
    end
  end

  assign sample_hold  = (state_r == ADSQ_SAMPLE);
  assign result_latch = (state_r == ADSQ_CONV) && last_tick;

  // Justification of the 12-bit result
  assign result_high_byte = result_format_select ? {4'h0, result_r[11:8]}
                                                 : result_r[11:4]; // R20
  assign result_low_byte  = result_format_select ? result_r[7:0]
                                                 : {result_r[3:0], 4'h0}; // R14

  ////////////////////////////////////////////////////////////////////////
  // Software registers; busy bit is read-only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl0_r     <= ADSQ_RST_CTRL0;
      ctrl1_r     <= ADSQ_RST_CTRL1;
      pinsel_r    <= ADSQ_RST_PINSEL;
      irq_en_r    <= 1'b0;
      master_en_r <= 1'b0;
    end else begin
      if (wr_c0) ctrl0_r <= wdata;
      if (wr_c1) ctrl1_r <= wdata;
      if (wr_pin) pinsel_r <= wdata;
      if (wr_irq) begin
        irq_en_r    <= wdata[ADSQ_IRQ_EN];
        master_en_r <= wdata[ADSQ_IRQ_MASTER];
      end
    end
  end

  assign rd_mux =
    (addr == ADSQ_ADDR_CTRL0) ? {start_r, busy_r, ctrl0_r[5:0]} :
    (addr == ADSQ_ADDR_CTRL1) ? ctrl1_r :
    (addr == ADSQ_ADDR_RES_HI) ? result_high_byte :
    (addr == ADSQ_ADDR_RES_LO) ? result_low_byte :
    (addr == ADSQ_ADDR_PINSEL) ? pinsel_r :
    (addr == ADSQ_ADDR_IRQ) ? {5'h00, master_en_r, irq_en_r, irq_flag_r} :
    8'h00;

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd ? rd_mux : 8'h00;
    end
  end
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Analogue power and routing. Power, reference and input routing are gated by
  // power enable so the analogue side is fully idle when off.
  assign analog_power_on = converter_power_enable; // R1 R17
  assign ref_route = converter_power_enable ? reference_source_select
                                            : ADSQ_REF_EXT; // R3
  assign ext_mode = (internal_input_select == 3'h0)
                 || (internal_input_select == 3'h6)
                 || (internal_input_select == 3'h7);
  assign analog_input_pins_sel =
    (converter_power_enable && ext_mode && !external_channel_select[3])
      ? 8'(8'h01 << external_channel_select[2:0]) : 8'h00; // R5
  assign internal_route = !converter_power_enable ? 5'h00 :
    {internal_input_select == ADSQ_INS_AOUT,
     internal_input_select == ADSQ_INS_SUP4,
     internal_input_select == ADSQ_INS_GND,
     internal_input_select == ADSQ_INS_AMP1,
     internal_input_select == ADSQ_INS_AMP0}; // R6

  // Pins set as analogue lose digital function, pull-up and direction
  assign pin_digital_disable = pinsel_r; // R8
  assign pin_pullup_disable  = pinsel_r; // R8
  assign pin_dir_override    = pinsel_r; // R9

  assign conversion_irq = irq_flag_r && irq_en_r && master_en_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_busy_on_start: assert property (@(posedge clock) disable iff (!nrst)
    start_fall && !busy_r |=> busy_r) else $error("busy not set"); // R19
  chk_sample_len: assert property (@(posedge clock) disable iff (!nrst)
    $rose(sample_hold) && conversion_clock_divider == 3'h0
      && converter_power_enable |-> sample_hold [*4] ##1 !sample_hold)
    else $error("sample length wrong"); // R10
  chk_flag_on_done: assert property (@(posedge clock) disable iff (!nrst)
    result_latch |=> irq_flag_r && !busy_r) else $error("done"); // R13
  chk_busy_tracks: assert property (@(posedge clock) disable iff (!nrst)
    busy_r == (state_r != ADSQ_IDLE)) else $error("busy mismatch"); // R13
  chk_power_gate: assert property (@(posedge clock) disable iff (!nrst)
    !analog_power_on |-> analog_input_pins_sel == 8'h00
      && internal_route == 5'h00) else $error("routing off"); // R17
  chk_float_chan: assert property (@(posedge clock) disable iff (!nrst)
    external_channel_select[3] |-> analog_input_pins_sel == 8'h00)
    else $error("float channel"); // R5
  chk_ref_amp: assert property (@(posedge clock) disable iff (!nrst)
    analog_power_on && reference_source_select == ADSQ_REF_AMP
      |-> ref_route == ADSQ_REF_AMP) else $error("ref route"); // R3
  chk_fmt_right: assert property (@(posedge clock) disable iff (!nrst)
    result_format_select |-> result_high_byte[7:4] == 4'h0)
    else $error("format"); // R20
  chk_no_start_off: assert property (@(posedge clock) disable iff (!nrst)
    !converter_power_enable && !busy_r |=> !busy_r)
    else $error("started unpowered"); // R1
endmodule : adsq_ctrl

// *** hw/adsq_pkg.sv ***
// Package: register map, field layout, codes and timing for the ADC control
// Summary of operation
// (R1) Analogue power enable output follows the power enable bit only.
// (R2) Software waits a settling delay after power-up before starting.
// (R3) Reference code 00 external pin, 01/11 supply, 10 amplifier output.
// (R4) Software avoids external reference pin when internal reference chosen.
// (R5) Internal select 000/110/111: channels 0-7 route pins, 8-15 float.
// (R6) Internal codes 001..101 route amp0, amp1, ground, supply/4, amp out.
// (R7) Software parks external channel before choosing an internal signal.
// (R8) Analogue pin disables other functions and pull-high resistor.
// (R9) Analogue pin enable overrides the port direction setting.
// (R10) Conversion takes 4 sample plus 12 convert periods, 16 total.
// (R11) Conversion runs in hardware without stalling the processor.
// (R12) Start bit low, high, low again initiates a conversion.
// (R13) Busy high during conversion, falls with result valid.
// (R14) Format bit chooses arrangement of result in high and low bytes.
// (R15) Software enables both interrupt enables to get a completion interrupt.
// (R16) Converter clock is the system clock through the selected divider.
// (R17) Power enable cleared means converter circuits draw no power.
// (R18) Clock select 000..111 divides by 1,2,4,...,128.
// (R19) Busy sets on initiation; completion sets interrupt request flag.
// (R20) 12-bit result left or right justified by the format bit.
package adsq_pkg;
  localparam logic [3:0] ADSQ_ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADSQ_ADDR_CTRL1   = 4'h1;
  localparam logic [3:0] ADSQ_ADDR_RES_HI  = 4'h2;
  localparam logic [3:0] ADSQ_ADDR_RES_LO  = 4'h3;
  localparam logic [3:0] ADSQ_ADDR_PINSEL  = 4'h4;
  localparam logic [3:0] ADSQ_ADDR_IRQ     = 4'h5;
  // Control 0 bit positions
  localparam int ADSQ_C0_START   = 7;
  localparam int ADSQ_C0_BUSY    = 6;
  localparam int ADSQ_C0_PWR     = 5;
  localparam int ADSQ_C0_FMT     = 4;
  localparam int ADSQ_C0_CHAN_LO = 0;
  // Control 1 bit positions
  localparam int ADSQ_C1_INS_LO  = 5;
  localparam int ADSQ_C1_REF_LO  = 3;
  localparam int ADSQ_C1_DIV_LO  = 0;
  // Interrupt control bit positions
  localparam int ADSQ_IRQ_FLAG   = 0;
  localparam int ADSQ_IRQ_EN     = 1;
  localparam int ADSQ_IRQ_MASTER = 2;
  // Reset values
  localparam logic [7:0] ADSQ_RST_CTRL0  = 8'h00;
  localparam logic [7:0] ADSQ_RST_CTRL1  = 8'h00;
  localparam logic [7:0] ADSQ_RST_PINSEL = 8'h00;
  // Sequence lengths in converter clock periods
  localparam logic [4:0] ADSQ_SAMPLE_CNT = 5'h04;
  localparam logic [4:0] ADSQ_TOTAL_CNT  = 5'h10;
  localparam int         ADSQ_RES_W      = 12;
  // Reference codes
  localparam logic [1:0] ADSQ_REF_EXT  = 2'h0;
  localparam logic [1:0] ADSQ_REF_AMP  = 2'h2;
  // Internal input codes
  localparam logic [2:0] ADSQ_INS_AMP0 = 3'h1;
  localparam logic [2:0] ADSQ_INS_AMP1 = 3'h2;
  localparam logic [2:0] ADSQ_INS_GND  = 3'h3;
  localparam logic [2:0] ADSQ_INS_SUP4 = 3'h4;
  localparam logic [2:0] ADSQ_INS_AOUT = 3'h5;

  typedef enum logic [2:0] {
    ADSQ_IDLE   = 3'b001,
    ADSQ_SAMPLE = 3'b010,
    ADSQ_CONV   = 3'b100
  } adsq_state_t;
endpackage : adsq_pkg

// *** sim/adc_sequencer_control_tb.sv ***
// Self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module adc_sequencer_control_tb;
  import adsq_pkg::*;
  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic       pwr;
    logic [1:0] rf;
    logic [7:0] pins;
    logic [4:0] irt;
  } adsq_row_t;
  logic        clock, nrst, wr, rd, analog_power_on, sample_hold;
  logic        result_latch, conversion_irq;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, pins_sel, pu_dis, dig_dis, dir_ovr, v;
  logic [11:0] conv_data;
  logic [1:0]  ref_route;
  logic [4:0]  internal_route;
  int          errors, tests_run;
  // Routing table: control words beside the routes they should produce
  adsq_row_t   rows [11] = '{
    '{8'h20, 8'h00, 1'b1, 2'h0, 8'h01, 5'h00},
    '{8'h27, 8'h08, 1'b1, 2'h1, 8'h80, 5'h00},
    '{8'h23, 8'hC0, 1'b1, 2'h0, 8'h08, 5'h00},
    '{8'h28, 8'hD0, 1'b1, 2'h2, 8'h00, 5'h00},
    '{8'h2F, 8'hF8, 1'b1, 2'h3, 8'h00, 5'h00},
    '{8'h28, 8'h20, 1'b1, 2'h0, 8'h00, 5'h01},
    '{8'h28, 8'h40, 1'b1, 2'h0, 8'h00, 5'h02},
    '{8'h28, 8'h60, 1'b1, 2'h0, 8'h00, 5'h04},
    '{8'h28, 8'h80, 1'b1, 2'h0, 8'h00, 5'h08},
    '{8'h28, 8'hA0, 1'b1, 2'h0, 8'h00, 5'h10},
    '{8'h03, 8'h08, 1'b0, 2'h0, 8'h00, 5'h00}};

  adsq_ctrl DUT (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .conv_data(conv_data),
    .analog_power_on(analog_power_on), .sample_hold(sample_hold),
    .result_latch(result_latch), .ref_route(ref_route),
    .analog_input_pins_sel(pins_sel), .internal_route(internal_route),
    .pin_pullup_disable(pu_dis), .pin_digital_disable(dig_dis),
    .pin_dir_override(dir_ovr), .conversion_irq(conversion_irq));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compare seen against expected, four-state exact
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe; slave never stalls
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data is only valid in the cycle after the strobe
  task rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Full conversion at one divider code, timed on the ports
  task conv(input logic [2:0] dv, input logic fmt, input logic [7:0] ic);
    int          n, sh;
    logic [11:0] r;
    n = 0;
    sh = 0;
    r = {dv, 9'h0A5} ^ 12'h3C3;
    conv_data <= r;
    wr_reg(ADSQ_ADDR_IRQ, ic);
    wr_reg(ADSQ_ADDR_CTRL1, {5'h00, dv});
    wr_reg(ADSQ_ADDR_CTRL0, {3'h1, fmt, 4'h0});
    // Let the analogue side settle before the start pulse
    repeat (8) @(posedge clock);
    wr_reg(ADSQ_ADDR_CTRL0, {3'h5, fmt, 4'h0});
    wr_reg(ADSQ_ADDR_CTRL0, {3'h1, fmt, 4'h0});
    // Busy starts at the edge that takes the falling write: count from there
    #1;
    while (result_latch !== 1'b1 && n < 20000) begin
      if (sample_hold === 1'b1) sh++;
      if (sh > 0) n++;
      @(posedge clock);
      #1;
    end
    n++;
    chk(16'(sh), 16'(4 << dv));
    chk(16'(n), 16'(16 << dv));
    @(posedge clock);
    #1 chk(16'(result_latch), 16'h0000);
    rd_reg(ADSQ_ADDR_CTRL0, v);
    chk(16'(v), {8'h00, 3'h1, fmt, 4'h0});
    rd_reg(ADSQ_ADDR_RES_HI, v);
    chk(16'(v), fmt ? {8'h00, 4'h0, r[11:8]} : {8'h00, r[11:4]});
    rd_reg(ADSQ_ADDR_RES_LO, v);
    chk(16'(v), fmt ? {8'h00, r[7:0]} : {8'h00, r[3:0], 4'h0});
    chk(16'(conversion_irq), 16'(ic == 8'h06));
    rd_reg(ADSQ_ADDR_IRQ, v);
    chk(16'(v), 16'(ic | 8'h01));
    $display("Test conversion divider %0d done", dv);
  endtask : conv

  // Verdict and end of run
  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the run needs roughly 4500 cycles
  initial begin
    #(20 * 40000);
    errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    nrst = 1'b0;
    {wr, rd, addr, wdata} = '0;
    conv_data = 12'h000;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1 chk({analog_power_on, sample_hold, result_latch, conversion_irq,
           ref_route, internal_route}, 16'h0000);
    rd_reg(ADSQ_ADDR_CTRL0, v);
    chk(16'(v), 16'(ADSQ_RST_CTRL0));
    rd_reg(ADSQ_ADDR_CTRL1, v);
    chk(16'(v), 16'(ADSQ_RST_CTRL1));
    @(posedge clock);
    #1 chk(16'(rdata), 16'h0000);
    rd_reg(4'hF, v);
    chk(16'(v), 16'h0000);
    $display("Test reset done");
    // Table of routing cases
    foreach (rows[i]) begin
      wr_reg(ADSQ_ADDR_CTRL0, rows[i].c0);
      wr_reg(ADSQ_ADDR_CTRL1, rows[i].c1);
      @(posedge clock);
      #1 chk(16'(analog_power_on), 16'(rows[i].pwr));
      chk(16'(ref_route), 16'(rows[i].rf));
      chk(16'(pins_sel), 16'(rows[i].pins));
      chk(16'(internal_route), 16'(rows[i].irt));
      rd_reg(ADSQ_ADDR_CTRL1, v);
      chk(16'(v), 16'(rows[i].c1));
    end
    $display("Test routing done");
    // Analogue pin select drives all three pin overrides
    wr_reg(ADSQ_ADDR_PINSEL, 8'hA5);
    @(posedge clock);
    #1 chk({pu_dis, dig_dis}, 16'hA5A5);
    chk(16'(dir_ovr), 16'h00A5);
    rd_reg(ADSQ_ADDR_PINSEL, v);
    chk(16'(v), 16'h00A5);
    $display("Test pin select done");
    // Start pulse while powered off is ignored
    wr_reg(ADSQ_ADDR_CTRL0, 8'h80);
    wr_reg(ADSQ_ADDR_CTRL0, 8'h00);
    repeat (4) begin
      @(posedge clock);
      #1 chk(16'(sample_hold), 16'h0000);
    end
    $display("Test start while off done");
    // Every divider code, both result formats, irq on and off
    for (int d = 0; d < 8; d++) begin
      conv(3'(d), d[0], (d == 3) ? 8'h02 : 8'h06);
    end
    // Abort by clearing power mid-conversion at the slowest divider
    wr_reg(ADSQ_ADDR_IRQ, 8'h06);
    wr_reg(ADSQ_ADDR_CTRL1, 8'h07);
    wr_reg(ADSQ_ADDR_CTRL0, 8'h20);
    repeat (8) @(posedge clock);
    wr_reg(ADSQ_ADDR_CTRL0, 8'hA0);
    wr_reg(ADSQ_ADDR_CTRL0, 8'h20);
    repeat (10) @(posedge clock);
    rd_reg(ADSQ_ADDR_CTRL0, v);
    chk({v, 7'h00, sample_hold}, 16'h6001);
    wr_reg(ADSQ_ADDR_CTRL0, 8'h00);
    rd_reg(ADSQ_ADDR_CTRL0, v);
    chk({v, 6'h00, sample_hold, analog_power_on}, 16'h0000);
    rd_reg(ADSQ_ADDR_IRQ, v);
    chk({v, 7'h00, conversion_irq}, 16'h0600);
    $display("Test abort done");
    report_and_stop();
  end
endmodule : adc_sequencer_control_tb
